// ==== rtl/dtf_pkg.sv ====
// Contract
// - address 1 reads error, writes feature
// - error contents valid; diagnostic code after reset
// - error bits: reserved, then seven causes
// - feature written idle, used at command
// - sector count read/write; zero means 256
// - error leaves remaining sectors in count
// - sector number holds start sector or address
// - error loads failing address into number
// - status read-only; write goes to command
// - status read clears pending interrupt
// - busy always valid; others invalid while busy
// - status bit order busy down to error
// - host writes ignored while busy
// - request changes only while busy, except last
// - idle device changes only live status bits
// - busy or request held until completion
// - busy within 400 ns of triggers
// - ready cleared at power on, held
// - not ready still accepts diagnostic, geometry
// - seek complete frozen after error
// - error state frozen until command or reset
// - linear bit selects block addressing; no linear bit is decoded here, the sector number is passed on unchanged
package dtf_pkg;
  // ****************************************
  // register decode
  // ****************************************
  localparam logic [1:0] CS_CMD_BLOCK = 2'h2;
  localparam logic [2:0] ADDR_ERR_FEAT = 3'h1;
  localparam logic [2:0] ADDR_SEC_CNT = 3'h2;
  localparam logic [2:0] ADDR_SEC_NUM = 3'h3;
  localparam logic [2:0] ADDR_STAT_CMD = 3'h7;
  // status bit positions
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_READY_BIT = 6;
  localparam int ST_FAULT_BIT = 5;
  localparam int ST_SEEK_BIT = 4;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_CORRECTED_DATA_FLAG_BIT = 2;
  localparam int ST_INDEX_BIT = 1;
  localparam int ST_ERR_BIT = 0;
  // error cause bits 6..0, bit 7 reserved and reads zero
  localparam int ERR_UNCORR_BIT = 6;
  localparam int ERR_MEDIA_CHG_BIT = 5;
  localparam int ERR_ID_MISS_BIT = 4;
  localparam int ERR_CHG_REQ_BIT = 3;
  localparam int ERR_ABORT_BIT = 2;
  localparam int ERR_TRK0_BIT = 1;
  localparam int ERR_AMARK_BIT = 0;
  // reset values
  localparam logic [7:0] REG_RST_VAL = 8'h00;
  localparam logic [8:0] SEC_CNT_FULL = 9'h100;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int BUSY_SET_MAX_NS = 400;
  localparam int BUSY_SET_CYC = (BUSY_SET_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (BUSY_SET_MAX_NS / CLK_PERIOD_NS);
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] cs;
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } dtf_host_t;
  typedef struct packed {
    logic diag_done;
    logic [7:0] diag_code;
    logic drq_set;
    logic block_gap;
    logic last_block;
    logic done;
    logic error;
    logic [6:0] err_bits;
    logic [7:0] remain_cnt;
    logic [7:0] err_sector;
  } dtf_core_t;
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] feature;
    logic [8:0] sectors;
    logic [7:0] start_sector;
  } dtf_cmd_t;
  typedef struct packed {
    logic ready;
    logic fault;
    logic seek;
    logic corrected_data_flag;
    logic index;
  } dtf_live_t;
endpackage

// ==== rtl/dtf_hold_bit.sv ====
`timescale 1ns/1ns
module dtf_hold_bit import dtf_pkg::*; #(
  parameter bit HOLD_ON_CHANGE = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic live_i,
  input wire logic freeze_i,
  input wire logic release_i,
  output logic q_o
);
  logic q_ff;
  logic hold_ff;
  logic nxt_q;
  logic nxt_hold;
  // follow the live level unless held; a freeze wins over a release
  always_comb begin
    nxt_q = q_ff;
    nxt_hold = hold_ff;
    if (freeze_i) begin
      nxt_hold = 1'b1;
    end else if (release_i || !hold_ff) begin
      nxt_q = live_i;
      nxt_hold = HOLD_ON_CHANGE && (live_i != q_ff) && !release_i;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      q_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q;
      hold_ff <= nxt_hold;
    end
  end
  assign q_o = q_ff;
  // held value must not move until a release
  hold_stable_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    hold_ff && !release_i |=> q_ff == $past(q_ff))
    else $error("held status bit changed before status read");
endmodule

// ==== rtl/dtf_intr_pend.sv ====
`timescale 1ns/1ns
module dtf_intr_pend import dtf_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic pend_o
);
  logic pend_ff;
  logic nxt_pend;
  // set wins, so a completion landing on the acknowledging read is kept
  always_comb begin
    nxt_pend = set_i ? 1'b1 : (clr_i ? 1'b0 : pend_ff);
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end
  assign pend_o = pend_ff;
  irq_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clr_i && !set_i |=> !pend_ff)
    else $error("pending interrupt survived status read");
endmodule

// ==== rtl/dtf_task_file.sv ====
`timescale 1ns/1ns
module dtf_task_file import dtf_pkg::*; #(
  parameter logic [7:0] DIAG_CODE_DFLT = 8'h01
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire dtf_host_t host_i,
  input wire dtf_core_t core_i,
  input wire dtf_live_t live_i,
  input wire logic soft_reset_bit_i,
  output logic [7:0] rdata_o,
  output logic rdata_oe_o,
  output logic intrq_o,
  output logic busy_flag_o,
  output logic data_request_flag_o,
  output dtf_cmd_t cmd_o
);
  // ****************************************
  // decode
  // ****************************************
  typedef enum logic [1:0] {
    ST_BUSY,
    ST_IDLE,
    ST_XFER
  } dtf_state_t;

  localparam int BUSY_BND = BUSY_SET_CYC;

  // single decode used for the status strobes and every register write hit
  function automatic logic hit(input dtf_host_t h, input logic [2:0] a);
    return (h.cs == CS_CMD_BLOCK) && (h.addr == a);
  endfunction

  dtf_state_t state_ff;
  dtf_state_t nxt_state;
  logic busy_ff;
  logic drq_ff;
  logic nxt_busy;
  logic nxt_drq;
  logic err_ff;
  logic nxt_err;
  logic [6:0] err_rep_ff;
  logic [6:0] nxt_err_rep;
  logic [7:0] feat_ff;
  logic [7:0] nxt_feat;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] num_ff;
  logic [7:0] nxt_num;
  logic [7:0] diag_ff;
  logic [7:0] nxt_diag;
  logic diag_valid_ff;
  logic nxt_diag_valid;
  logic soft_reset_bit_q_ff;
  dtf_cmd_t cmd_ff;
  dtf_cmd_t nxt_cmd;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rdata_oe_ff;
  logic nxt_rdata_oe;
  logic soft_reset_bit_rise;
  logic cmd_wr;
  logic cmd_accept;
  logic stat_rd;
  logic wr_ok;
  logic complete;
  logic err_complete;
  logic irq_set;
  logic ready_q;
  logic seek_q;
  logic [7:0] status_val;

  // only the command block chip select decodes
  assign stat_rd = host_i.rd && hit(host_i, ADDR_STAT_CMD);
  assign cmd_wr = host_i.wr && hit(host_i, ADDR_STAT_CMD);
  assign wr_ok = host_i.wr && !busy_ff;
  // command starts busy only from idle (neither busy nor request), with the soft reset bit low
  assign cmd_accept = cmd_wr && (state_ff == ST_IDLE) && !soft_reset_bit_i;
  assign soft_reset_bit_rise = soft_reset_bit_i && !soft_reset_bit_q_ff;
  // completion by the engine or by the last pio block
  assign err_complete = (state_ff == ST_BUSY) && core_i.done && core_i.error && !soft_reset_bit_i;
  assign complete = (core_i.done && state_ff == ST_BUSY) || (core_i.last_block && state_ff == ST_XFER);
  assign irq_set = !soft_reset_bit_i && (complete || (state_ff == ST_BUSY && core_i.drq_set));

  // ****************************************
  // busy and data request sequencing
  // ****************************************
  // busy or request stays up from command to completion
  always_comb begin
    nxt_state = state_ff;
    if (soft_reset_bit_rise || soft_reset_bit_i) begin
      nxt_state = ST_BUSY;
    end else begin
      unique case (state_ff)
        ST_BUSY: begin
          if (core_i.done || (core_i.diag_done && !cmd_ff.valid && diag_valid_ff == 1'b0)) begin
            nxt_state = ST_IDLE;
          end else if (core_i.drq_set) begin
            nxt_state = ST_XFER;
          end
        end
        ST_IDLE: begin
          if (cmd_accept) begin
            nxt_state = ST_BUSY;
          end
        end
        ST_XFER: begin
          // last pio block drops request without busy
          if (core_i.last_block) begin
            nxt_state = ST_IDLE;
          end else if (core_i.block_gap) begin
            nxt_state = ST_BUSY;
          end
        end
      endcase
    end
    nxt_busy = (nxt_state == ST_BUSY);
    nxt_drq = (nxt_state == ST_XFER);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_BUSY;
      busy_ff <= 1'b1;
      drq_ff <= 1'b0;
      soft_reset_bit_q_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      drq_ff <= nxt_drq;
      soft_reset_bit_q_ff <= soft_reset_bit_i;
    end
  end

  // ****************************************
  // task file registers
  // ****************************************
  // idle device leaves registers
  // device updates happen only while busy, host loads only when idle
  always_comb begin
    nxt_err = err_ff;
    nxt_err_rep = err_rep_ff;
    nxt_feat = feat_ff;
    nxt_cnt = cnt_ff;
    nxt_num = num_ff;
    nxt_diag = diag_ff;
    nxt_diag_valid = diag_valid_ff;
    // write at error address lands in feature
    if (wr_ok && !drq_ff && hit(host_i, ADDR_ERR_FEAT)) begin
      nxt_feat = host_i.wdata;
    end
    if (wr_ok && !drq_ff && hit(host_i, ADDR_SEC_CNT)) begin
      nxt_cnt = host_i.wdata;
    end
    if (wr_ok && !drq_ff && hit(host_i, ADDR_SEC_NUM)) begin
      nxt_num = host_i.wdata;
    end
    // error state released by a new command
    if (cmd_accept) begin
      nxt_err = 1'b0;
    end
    // diagnostic code after reset or self test
    if (state_ff == ST_BUSY && core_i.diag_done) begin
      nxt_diag = core_i.diag_code;
      nxt_diag_valid = 1'b1;
      nxt_err_rep = core_i.diag_code[6:0];
    end
    if (err_complete) begin
      nxt_err = 1'b1;
      nxt_err_rep = core_i.err_bits;
      nxt_cnt = core_i.remain_cnt;
      nxt_num = core_i.err_sector;
    end
    // software reset also releases the error state
    if (soft_reset_bit_rise) begin
      nxt_err = 1'b0;
      nxt_diag_valid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      err_ff <= 1'b0;
      err_rep_ff <= DIAG_CODE_DFLT[6:0];
      feat_ff <= REG_RST_VAL;
      cnt_ff <= REG_RST_VAL;
      num_ff <= REG_RST_VAL;
      diag_ff <= DIAG_CODE_DFLT;
      diag_valid_ff <= 1'b0;
    end else begin
      err_ff <= nxt_err;
      err_rep_ff <= nxt_err_rep;
      feat_ff <= nxt_feat;
      cnt_ff <= nxt_cnt;
      num_ff <= nxt_num;
      diag_ff <= nxt_diag;
      diag_valid_ff <= nxt_diag_valid;
    end
  end

  // ****************************************
  // command issue
  // ****************************************
  // every code is accepted even while not ready
  always_comb begin
    nxt_cmd = '0;
    nxt_cmd.valid = cmd_accept;
    nxt_cmd.code = host_i.wdata;
    // feature handed over with the code
    nxt_cmd.feature = feat_ff;
    // zero count means full 256 sectors
    nxt_cmd.sectors = (cnt_ff == 8'h00) ? SEC_CNT_FULL : {1'b0, cnt_ff};
    // number passed unchanged, addressing mode decoded downstream
    nxt_cmd.start_sector = num_ff;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cmd_ff <= '0;
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  // ****************************************
  // status bits and interrupt
  // ****************************************
  // ready cleared at reset, held after a change until status read
  dtf_hold_bit #(
    .HOLD_ON_CHANGE(1'b1)
  ) u_ready (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .live_i(live_i.ready),
    .freeze_i(1'b0),
    .release_i(stat_rd),
    .q_o(ready_q)
  );

  // seek complete frozen by an error until status read
  dtf_hold_bit #(
    .HOLD_ON_CHANGE(1'b0)
  ) u_seek (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .live_i(live_i.seek),
    .freeze_i(err_complete),
    .release_i(stat_rd),
    .q_o(seek_q)
  );

  dtf_intr_pend u_irq (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(irq_set),
    .clr_i(stat_rd),
    .pend_o(intrq_o)
  );

  // other bits read zero while busy
  always_comb begin
    status_val = 8'h00;
    status_val[ST_BUSY_BIT] = busy_ff;
    if (!busy_ff) begin
      status_val[ST_READY_BIT] = ready_q;
      status_val[ST_FAULT_BIT] = live_i.fault;
      status_val[ST_SEEK_BIT] = seek_q;
      status_val[ST_DRQ_BIT] = drq_ff;
      status_val[ST_CORRECTED_DATA_FLAG_BIT] = live_i.corrected_data_flag;
      status_val[ST_INDEX_BIT] = live_i.index;
      status_val[ST_ERR_BIT] = err_ff;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // registered read data, one cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    nxt_rdata_oe = 1'b0;
    if (host_i.rd && host_i.cs == CS_CMD_BLOCK) begin
      nxt_rdata_oe = 1'b1;
      unique case (host_i.addr)
        // read at shared address returns error report
        ADDR_ERR_FEAT: nxt_rdata = {1'b0, err_rep_ff};
        ADDR_SEC_CNT: nxt_rdata = cnt_ff;
        ADDR_SEC_NUM: nxt_rdata = num_ff;
        // status read-only at the command address
        ADDR_STAT_CMD: nxt_rdata = status_val;
        // other addresses of this block are not answered and leave the bus undriven
        default: nxt_rdata_oe = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_ff <= 8'h00;
      rdata_oe_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rdata_oe_ff <= nxt_rdata_oe;
    end
  end

  assign rdata_o = rdata_ff;
  assign rdata_oe_o = rdata_oe_ff;
  assign busy_flag_o = busy_ff;
  assign data_request_flag_o = drq_ff;
  assign cmd_o = cmd_ff;

  // ****************************************
  // checks
  // ****************************************
  busy_write_ign_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    busy_ff && host_i.wr && !core_i.done |=> cnt_ff == $past(cnt_ff) && feat_ff == $past(feat_ff))
    else $error("register changed by host write while busy");
  cmd_busy_rise_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_accept |-> ##[1:BUSY_BND] busy_ff)
    else $error("busy not raised after command write");
  reset_busy_a: assert property (@(posedge sys_clk_i)
    $past(sys_rst_i) && !sys_rst_i |-> busy_ff)
    else $error("busy not set after reset release");
  drq_change_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $changed(drq_ff) |-> $past(busy_ff) || busy_ff || $past(core_i.last_block))
    else $error("data request changed while not busy");
  err_freeze_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    err_ff && !cmd_accept && !soft_reset_bit_rise ##1 1'b1 |-> err_ff && err_rep_ff == $past(err_rep_ff)
      && num_ff == $past(num_ff) || $past(host_i.wr))
    else $error("error state changed while frozen");
  err_read_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    host_i.rd && hit(host_i, ADDR_ERR_FEAT) |=> rdata_oe_ff && rdata_ff == {1'b0, $past(err_rep_ff)})
    else $error("error report not returned at shared address");
  other_cs_quiet_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    host_i.cs != CS_CMD_BLOCK |=> !rdata_oe_ff)
    else $error("read data driven for foreign chip select");
  busy_mask_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    busy_ff |-> status_val == 8'h80)
    else $error("status bits shown while busy");
  cmd_active_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_accept ##1 !complete [*2] |-> busy_ff || drq_ff)
    else $error("neither busy nor request during command");
  zero_count_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_accept && cnt_ff == 8'h00 |=> cmd_ff.sectors == 9'h100)
    else $error("zero count not expanded to 256");
endmodule

// ==== tb/dtf_host_model.sv ====
`timescale 1ns/1ns
module dtf_host_model import dtf_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rdata_oe_i,
  output dtf_host_t host_o
);
  // ****************************************
  // host adapter cycles
  // ****************************************
  initial begin
    host_o = '0;
  end
  // one request held across one sampling edge, answer taken one cycle later
  task automatic xfer(input logic [1:0] cs, input logic [2:0] addr, input logic wr, input logic [7:0] wdata,
                      output logic [7:0] rdata, output logic oe);
    if (!wr && addr == ADDR_STAT_CMD) begin
      repeat (BUSY_SET_CYC) @(negedge sys_clk_i);
    end
    @(negedge sys_clk_i);
    host_o.cs = cs;
    host_o.addr = addr;
    host_o.rd = !wr;
    host_o.wr = wr;
    host_o.wdata = wdata;
    @(negedge sys_clk_i);
    rdata = rdata_i;
    oe = rdata_oe_i;
    // released bus shows the inverse so stale data never looks valid
    host_o.rd = 1'h0;
    host_o.wr = 1'h0;
    host_o.cs = 2'h0;
    host_o.wdata = ~wdata;
  endtask
endmodule

// ==== tb/disk_task_file_status_test.sv ====
`timescale 1ns/1ns
module disk_task_file_status_test import dtf_pkg::*;;
  logic sys_clk_i;
  logic sys_rst_i;
  dtf_host_t host;
  dtf_core_t core;
  dtf_live_t live;
  logic soft_reset_bit;
  logic [7:0] rdata;
  logic oe;
  logic intrq;
  logic busy;
  logic data_request_flag;
  dtf_cmd_t cmd;
  int errors;
  int checked;

  dtf_host_model u_dtf_host_model (
    .sys_clk_i(sys_clk_i),
    .rdata_i(rdata),
    .rdata_oe_i(oe),
    .host_o(host)
  );
  dtf_task_file u_dtf_task_file (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .host_i(host),
    .core_i(core),
    .live_i(live),
    .soft_reset_bit_i(soft_reset_bit),
    .rdata_o(rdata),
    .rdata_oe_o(oe),
    .intrq_o(intrq),
    .busy_flag_o(busy),
    .data_request_flag_o(data_request_flag),
    .cmd_o(cmd)
  );

  // ****************************************
  // helpers
  // ****************************************
  always #4 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic o;
    u_dtf_host_model.xfer(CS_CMD_BLOCK, a, 1'h1, d, r, o);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string name);
    logic [7:0] r;
    logic o;
    u_dtf_host_model.xfer(CS_CMD_BLOCK, a, 1'h0, 8'h00, r, o);
    chk({name, " oe"}, 9'h001, {8'h00, o});
    chk(name, {1'h0, exp}, {1'h0, r});
  endtask

  // core event pulse for one cycle, flags checked after it lands
  task automatic ev(input dtf_core_t c);
    @(negedge sys_clk_i);
    core = c;
    @(negedge sys_clk_i);
    core = '0;
  endtask

  task automatic flags(input logic b, input logic q, input logic i);
    chk("busy", {8'h00, b}, {8'h00, busy});
    chk("data request", {8'h00, q}, {8'h00, data_request_flag});
    chk("interrupt", {8'h00, i}, {8'h00, intrq});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // watchdog
  // ****************************************
  // ten settled status reads of 50 cycles each plus short cycles
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    errors++;
    $display("ERROR watchdog expected finish seen timeout");
    summarize();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [7:0] r;
    logic o;
    sys_clk_i = 1'h0;
    sys_rst_i = 1'h1;
    core = '0;
    live = '{ready: 1'h1, seek: 1'h1, default: '0};
    soft_reset_bit = 1'h0;
    errors = 0;
    checked = 0;
    repeat (10) @(negedge sys_clk_i);
    sys_rst_i = 1'h0;
    @(negedge sys_clk_i);
    flags(1'h1, 1'h0, 1'h0);
    rd(ADDR_STAT_CMD, 8'h80, "status busy");
    wr(ADDR_SEC_CNT, 8'h55);
    ev('{diag_done: 1'h1, diag_code: 8'h01, default: '0});
    chk("busy after diag", 9'h000, {8'h00, busy});
    rd(ADDR_ERR_FEAT, 8'h01, "diag code");
    rd(ADDR_SEC_CNT, 8'h00, "count ignored");
    u_dtf_host_model.xfer(CS_CMD_BLOCK, ADDR_STAT_CMD, 1'h0, 8'h00, r, o);
    rd(ADDR_STAT_CMD, 8'h50, "status idle");
    $display("test reset done");

    // feature write hidden behind the error read at its shared address
    wr(ADDR_SEC_CNT, 8'hA5);
    wr(ADDR_SEC_NUM, 8'h3C);
    wr(ADDR_ERR_FEAT, 8'h7E);
    rd(ADDR_SEC_CNT, 8'hA5, "count");
    rd(ADDR_SEC_NUM, 8'h3C, "number");
    rd(ADDR_ERR_FEAT, 8'h01, "error not feature");
    u_dtf_host_model.xfer(2'h1, ADDR_SEC_CNT, 1'h1, 8'hFF, r, o);
    u_dtf_host_model.xfer(2'h1, ADDR_SEC_CNT, 1'h0, 8'h00, r, o);
    chk("other cs oe", 9'h000, {8'h00, o});
    u_dtf_host_model.xfer(CS_CMD_BLOCK, 3'h5, 1'h0, 8'h00, r, o);
    chk("unmapped oe", 9'h000, {8'h00, o});
    rd(ADDR_SEC_CNT, 8'hA5, "count kept");
    $display("test registers done");

    wr(ADDR_SEC_CNT, 8'h00);
    wr(ADDR_STAT_CMD, 8'h20);
    chk("cmd start", 9'h03C, {1'h0, cmd.start_sector});
    chk("cmd valid", 9'h001, {8'h00, cmd.valid});
    chk("cmd code", 9'h020, {1'h0, cmd.code});
    chk("cmd feature", 9'h07E, {1'h0, cmd.feature});
    chk("cmd sectors", SEC_CNT_FULL, cmd.sectors);
    chk("busy on cmd", 9'h001, {8'h00, busy});
    ev('{done: 1'h1, default: '0});
    flags(1'h0, 1'h0, 1'h1);
    rd(ADDR_STAT_CMD, 8'h50, "status done");
    chk("interrupt cleared", 9'h000, {8'h00, intrq});
    live.fault = 1'h1;
    live.corrected_data_flag = 1'h1;
    live.index = 1'h1;
    rd(ADDR_STAT_CMD, 8'h76, "status live bits");
    live.fault = 1'h0;
    live.corrected_data_flag = 1'h0;
    live.index = 1'h0;
    $display("test command done");

    wr(ADDR_SEC_CNT, 8'h02);
    wr(ADDR_STAT_CMD, 8'h30);
    chk("cmd sectors 2", 9'h002, cmd.sectors);
    ev('{drq_set: 1'h1, default: '0});
    flags(1'h0, 1'h1, 1'h1);
    wr(ADDR_SEC_CNT, 8'h77);
    ev('{block_gap: 1'h1, default: '0});
    chk("busy in gap", 9'h001, {8'h00, busy});
    ev('{drq_set: 1'h1, default: '0});
    chk("request again", 9'h001, {8'h00, data_request_flag});
    ev('{last_block: 1'h1, default: '0});
    chk("busy after last", 9'h000, {8'h00, busy});
    chk("request after last", 9'h000, {8'h00, data_request_flag});
    rd(ADDR_STAT_CMD, 8'h50, "status pio");
    rd(ADDR_SEC_CNT, 8'h02, "count not rewritten");
    $display("test pio done");

    wr(ADDR_STAT_CMD, 8'hC8);
    ev('{done: 1'h1, error: 1'h1, err_bits: 7'h04, remain_cnt: 8'h03, err_sector: 8'h11, default: '0});
    flags(1'h0, 1'h0, 1'h1);
    live.seek = 1'h0;
    rd(ADDR_STAT_CMD, 8'h51, "seek frozen");
    rd(ADDR_STAT_CMD, 8'h41, "seek live");
    ev('{done: 1'h1, error: 1'h1, err_bits: 7'h40, remain_cnt: 8'h09, default: '0});
    rd(ADDR_ERR_FEAT, 8'h04, "error bits");
    rd(ADDR_SEC_CNT, 8'h03, "remaining");
    rd(ADDR_SEC_NUM, 8'h11, "error sector");
    wr(ADDR_STAT_CMD, 8'hEC);
    ev('{done: 1'h1, default: '0});
    rd(ADDR_STAT_CMD, 8'h40, "error cleared");
    $display("test error done");

    wr(ADDR_STAT_CMD, 8'hC8);
    ev('{done: 1'h1, error: 1'h1, err_bits: 7'h10, default: '0});
    soft_reset_bit = 1'h1;
    repeat (2) @(negedge sys_clk_i);
    chk("busy soft reset", 9'h001, {8'h00, busy});
    soft_reset_bit = 1'h0;
    ev('{diag_done: 1'h1, diag_code: 8'h01, default: '0});
    rd(ADDR_ERR_FEAT, 8'h01, "diag after soft");
    rd(ADDR_STAT_CMD, 8'h40, "no error after soft");
    $display("test soft reset done");
    summarize();
  end
endmodule
